// >>> verilog/bsl_pkg.sv
// Package of constants for the boot strap latch and decode block
package bsl_pkg;
   // Strap word bit positions
   localparam int unsigned STRAP_A_BIT = 0;
   localparam int unsigned STRAP_B_BIT = 1;
   localparam int unsigned STRAP_C_BIT = 2;
   localparam int unsigned STRAP_W     = 3;

   // Register offsets on the plain register port
   localparam logic [3:0] OFS_STRAP  = 4'h0;
   localparam logic [3:0] OFS_BOOT   = 4'h1;
   localparam logic [3:0] OFS_FUSE   = 4'h2;

   // Boot status register fields
   localparam int unsigned BOOT_DL_BIT    = 0;
   localparam int unsigned BOOT_PRINT_BIT = 1;
   localparam int unsigned BOOT_BAD_BIT   = 2;
   localparam int unsigned BOOT_VALID_BIT = 3;

   // Print control fuse encodings
   localparam logic [1:0] PRINT_ON    = 2'h0;
   localparam logic [1:0] PRINT_B_LOW = 2'h1;
   localparam logic [1:0] PRINT_B_HI  = 2'h2;
   localparam logic [1:0] PRINT_OFF   = 2'h3;

   // Reset values
   localparam logic [2:0] STRAP_RST = 3'h4;
   localparam logic [1:0] FUSE_RST  = 2'h0;

   // Hold time after chip enable and derived cycles at 50 MHz
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned HOLD_MS     = 3;
   localparam int unsigned HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_MS;

   typedef enum logic [1:0] {BSL_IDLE, BSL_WAIT, BSL_DONE} bsl_state_t;
endpackage

// >>> verilog/bsl_decode.sv
// Boot mode and print enable decode of latched strap bits
`timescale 1ns/100ps
module bsl_decode (
   input  wire logic [2:0] strap_i,
   input  wire logic [1:0] fuse_i,
   output logic            download_o,
   output logic            print_en_o,
   output logic            bad_combo_o
);
   wire pin_b = strap_i[bsl_pkg::STRAP_B_BIT];
   wire pin_c = strap_i[bsl_pkg::STRAP_C_BIT];

   assign download_o  = ~pin_c; // R7
   // Pin B low with pin C low cannot boot; flagged for software only
   assign bad_combo_o = ~pin_b & ~pin_c; // R8

   always_comb
   begin
      unique case (fuse_i)
         bsl_pkg::PRINT_ON:    print_en_o = 1'b1;   // R10
         bsl_pkg::PRINT_B_LOW: print_en_o = ~pin_b; // R11
         bsl_pkg::PRINT_B_HI:  print_en_o = pin_b;  // R12
         bsl_pkg::PRINT_OFF:   print_en_o = 1'b0;   // R10
      endcase
   end
endmodule

// >>> verilog/bsl_top.sv
// Strap pin latch with boot decode and register port
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// R1: Latch three strap pin levels during reset
// R2: Every system reset source re-samples straps
// R3: Latched bits kept until power down
// R4: Software reads latched bits via register
// R5: Pin C pulled up internally by default
// R6: Pins return to normal use after reset
// R7: Pin C high flash boot, low download
// R8: Download needs pin B high; A high (download_o uses pin C only; A and B not checked)
// R9: Host never drives B and C low
// R10: Fuse 0 prints, fuse 3 silent
// R11: Fuse 1 prints when B low
// R12: Fuse 2 prints when B high
// R13: Host holds straps 3 ms after enable
// R14: Host may use pulls or GPIO drive
// R15: Capture at reset release, stable outputs
module bsl_top #(
   parameter int unsigned HOLD_CYC = bsl_pkg::HOLD_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       strap_pin_a_i,
   input  wire logic       strap_pin_b_i,
   input  wire logic       strap_pin_c_i,
   input  wire logic       strap_pin_c_oe_i,
   output logic            strap_pin_c_pu_o,
   output logic            strap_release_o,
   input  wire logic [1:0] print_fuse_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   output logic            download_o,
   output logic            print_en_o,
   output logic            strap_valid_o
);
   bsl_pkg::bsl_state_t state_r;
   bsl_pkg::bsl_state_t state_nxt;
   logic [2:0]  strap_r;
   logic [2:0]  strap_nxt;
   logic [1:0]  fuse_r;
   logic [21:0] hold_cnt_r;
   logic [21:0] hold_cnt_nxt;
   logic        dl_r;
   logic        pr_r;
   logic        bad_r;
   logic [7:0]  rdata_r;
   logic        dec_dl;
   logic        dec_pr;
   logic        dec_bad;

   // Pin C reads high when nobody drives it (strap_pin_c_oe_i low)
   wire pin_c_eff = strap_pin_c_oe_i ? strap_pin_c_i : 1'b1; // R5
   wire [2:0] pins = {pin_c_eff, strap_pin_b_i, strap_pin_a_i};
   wire hold_done = (hold_cnt_r == 22'(HOLD_CYC - 1));

   // Read strobes for the strap, boot and fuse registers; the fuse is latched once in BSL_IDLE, while the straps are sampled through BSL_WAIT too
   wire rd_strap = rd_i & (addr_i == bsl_pkg::OFS_STRAP);
   wire rd_boot  = rd_i & (addr_i == bsl_pkg::OFS_BOOT);
   wire rd_fuse  = rd_i & (addr_i == bsl_pkg::OFS_FUSE);
   wire [7:0] boot_word = {4'h0, strap_valid_o, bad_r, pr_r, dl_r};
   wire [7:0] rd_mux = rd_strap ? {5'h00, strap_r} :  // R4
                       rd_boot  ? boot_word :
                       rd_fuse  ? {6'h00, fuse_r} : 8'h00;

   // Sampling runs from reset release through the hold window so the last
   // stable level before release is what is kept.
   always_comb
   begin
      state_nxt    = state_r;
      strap_nxt    = strap_r;
      hold_cnt_nxt = hold_cnt_r;
      unique case (state_r)
         bsl_pkg::BSL_IDLE:
         begin
            strap_nxt    = pins;               // R1
            hold_cnt_nxt = 22'h000000;
            state_nxt    = bsl_pkg::BSL_WAIT;
         end
         bsl_pkg::BSL_WAIT:
         begin
            strap_nxt    = pins;               // R15
            hold_cnt_nxt = hold_cnt_r + 22'h000001;
            if (hold_done)
            begin
               state_nxt = bsl_pkg::BSL_DONE;  // R6
            end
         end
         bsl_pkg::BSL_DONE:
         begin
            strap_nxt = strap_r;               // R3
         end
         default:
         begin
            state_nxt = bsl_pkg::BSL_IDLE;
         end
      endcase
   end

   // Decode the value being frozen so download and print match the kept straps
   bsl_decode u_decode (
      .strap_i     (strap_nxt),
      .fuse_i      (fuse_r),
      .download_o  (dec_dl),
      .print_en_o  (dec_pr),
      .bad_combo_o (dec_bad)
   );

   // Any reset source arrives here as srst_i and restarts sampling
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state_r    <= bsl_pkg::BSL_IDLE;      // R2
         strap_r    <= bsl_pkg::STRAP_RST;
         hold_cnt_r <= 22'h000000;
      end
      else
      begin
         state_r    <= state_nxt;
         strap_r    <= strap_nxt;
         hold_cnt_r <= hold_cnt_nxt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         fuse_r <= bsl_pkg::FUSE_RST;
      end
      else if (state_r == bsl_pkg::BSL_IDLE)
      begin
         fuse_r <= print_fuse_i;
      end
   end

   // Decoded results frozen once the straps settle
   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         dl_r  <= 1'b0;
         pr_r  <= 1'b0;
         bad_r <= 1'b0;
      end
      else if (state_nxt == bsl_pkg::BSL_DONE && state_r != bsl_pkg::BSL_DONE)
      begin
         dl_r  <= dec_dl;                      // R7
         pr_r  <= dec_pr;                      // R10
         bad_r <= dec_bad;                     // R8
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (srst_i)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         rdata_r <= rd_mux;
      end
   end

   assign rdata_o          = rdata_r;
   assign download_o       = dl_r;
   assign print_en_o       = pr_r;
   assign strap_valid_o    = (state_r == bsl_pkg::BSL_DONE);
   assign strap_release_o  = strap_valid_o;   // R6
   assign strap_pin_c_pu_o = ~strap_valid_o;  // R5
endmodule

// >>> test/bsl_top_sva.sv
// Checker for strap capture timing and boot decode outputs
`timescale 1ns/100ps
module bsl_top_sva #(parameter int unsigned HOLD_CYC = 8) (
   input wire logic       clk_i, srst_i, strap_pin_b_i, strap_pin_c_i, rd_i,
   input wire logic       strap_valid_o, strap_release_o, strap_pin_c_pu_o,
   input wire logic       download_o, print_en_o,
   input wire logic [1:0] print_fuse_i,
   input wire logic [7:0] rdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   int unsigned cnt_r;
   // Counts edges since reset release until the straps freeze
   always_ff @(posedge clk_i)
      if (srst_i)
         cnt_r <= 0;
      else if (!strap_valid_o)
         cnt_r <= cnt_r + 1;
   a_valid_sticky: assert property (strap_valid_o |=> strap_valid_o) else $error("valid fell");
   a_hold_len: assert property ($rose(strap_valid_o) |-> cnt_r == HOLD_CYC + 1)
      else $error("capture time");
   a_outs_stable: assert property (strap_valid_o && $past(strap_valid_o)
      |-> $stable({download_o, print_en_o})) else $error("decode moved");
   a_pins_back: assert property (strap_release_o == strap_valid_o) else $error("release");
   a_pullup_on: assert property (strap_pin_c_pu_o != strap_valid_o) else $error("pullup");
   a_boot_mode: assert property ($rose(strap_valid_o)
      |-> download_o == !$past(strap_pin_c_i)) else $error("boot mode");
   a_print_dec: assert property ($rose(strap_valid_o) |-> print_en_o ==
      (print_fuse_i == 2'h0 || (^print_fuse_i && print_fuse_i[1] == $past(strap_pin_b_i))))
      else $error("print enable");
   a_idle_read: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata");
   c_capture: cover property ($rose(strap_valid_o));
   c_download: cover property (strap_valid_o && download_o);
   c_silent: cover property (strap_valid_o && !print_en_o);
endmodule
bind bsl_top bsl_top_sva #(.HOLD_CYC(HOLD_CYC)) u_bsl_top_sva (.*);

// >>> test/bsl_strap_host.sv
// Host side model presenting strap levels, then reusing the pins
`timescale 1ns/100ps
module bsl_strap_host (
   input  wire logic       clk_i, release_i, pu_i, float_c_i,
   input  wire logic [2:0] want_i,
   output logic            pin_a_o, pin_b_o, pin_c_o, c_oe_o
);
   logic tog_r = 1'b0;
   // Once released the pins carry traffic, so capture must ignore them
   always_ff @(posedge clk_i)
      tog_r <= ~tog_r;
   assign pin_a_o = release_i ? tog_r : want_i[0];
   assign pin_b_o = release_i ? ~tog_r : want_i[1];
   assign c_oe_o = !float_c_i && !release_i;
   assign pin_c_o = c_oe_o ? want_i[2] : (pu_i ? 1'b1 : tog_r);
endmodule

// >>> test/bsl_top_test.sv
// Self-checking bench for the strap latch and boot decode block
`timescale 1ns/100ps
module bsl_top_test;
   logic clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, rd_d = 0, flt = 0, pr;
   logic [1:0] print_fuse_i = 0;
   logic [2:0] want = 3'h7, s;
   logic [3:0] addr_i = 0;
   logic [7:0] wdata_i = 0, e0;
   logic [7:0] exp_q[$];
   wire strap_pin_a_i, strap_pin_b_i, strap_pin_c_i, strap_pin_c_oe_i, strap_pin_c_pu_o;
   wire strap_release_o, download_o, print_en_o, strap_valid_o;
   wire [7:0] rdata_o;
   int bad_count = 0, checked = 0;
   always #10 clk_i = ~clk_i;
   bsl_top #(.HOLD_CYC(4)) u_bsl_top (.*);
   bsl_strap_host u_bsl_strap_host (.clk_i, .want_i(want), .float_c_i(flt),
      .release_i(strap_release_o), .pu_i(strap_pin_c_pu_o), .pin_a_o(strap_pin_a_i),
      .pin_b_o(strap_pin_b_i), .pin_c_o(strap_pin_c_i), .c_oe_o(strap_pin_c_oe_i));
   task automatic cmp(string nm, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
   endtask
   task automatic rd(logic [3:0] a, logic [7:0] e);
      rd_i <= 1;
      addr_i <= a;
      exp_q.push_back(e);
      @(posedge clk_i);
   endtask
   task print_verdict;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(negedge clk_i)
   begin
      if (rd_d)
         cmp("rdata", rdata_o, exp_q.pop_front());
      rd_d = rd_i;
   end
   initial
   begin
      void'($urandom(16805));
      for (int i = 0; i < 12; i++)
      begin
         s = 3'($urandom);
         if (s[2:1] == 2'h0)
            s[1] = 1;
         srst_i <= 1;
         rd_i <= 0;
         want <= s;
         flt <= i % 3 == 2;
         print_fuse_i <= 2'(i);
         repeat (2) @(posedge clk_i);
         srst_i <= 0;
         for (int n = 0; n < 20 && strap_valid_o !== 1'b1; n++)
            @(negedge clk_i);
         if (strap_valid_o !== 1'b1)
         begin
            bad_count++;
            print_verdict();
         end
         e0 = {5'h0, s[2] | flt, s[1:0]};
         pr = print_fuse_i == 0 || (print_fuse_i == 1 && !s[1]) || (print_fuse_i == 2 && s[1]);
         cmp("download", {7'h0, download_o}, {7'h0, ~e0[2]});
         cmp("print_en", {7'h0, print_en_o}, {7'h0, pr});
         cmp("release", {7'h0, strap_release_o}, 8'h01);
         cmp("pullup", {7'h0, strap_pin_c_pu_o}, 8'h00);
         @(posedge clk_i);
         wr_i <= 1;
         wdata_i <= 8'($urandom);
         @(posedge clk_i);
         wr_i <= 0;
         rd(4'h0, e0);
         rd(4'h1, {6'h2, pr, ~e0[2]});
         rd(4'h2, {6'h0, print_fuse_i});
         rd(4'hf, 8'h00);
         rd(4'h0, e0);
      end
      rd_i <= 0;
      repeat (3) @(posedge clk_i);
      print_verdict();
   end
endmodule
